// ---- verilog/vpbwd_map.svh ----
`ifndef VPBWD_MAP_SVH
`define VPBWD_MAP_SVH
`define VPBWD_OFF_PF_BASE 8'h24
`define VPBWD_OFF_PF_LIMIT 8'h26
`define VPBWD_OFF_BRIDGE_CTRL 8'h3E
`define VPBWD_OFF_IRQ_STATUS 8'h80
`define VPBWD_OFF_IRQ_MASK 8'h84
`define VPBWD_RST_PF_BASE 16'hFFF0
`define VPBWD_RST_PF_LIMIT 16'h0000
`define VPBWD_RST_BRIDGE_CTRL 8'h00
`define VPBWD_RST_IRQ_MASK 4'h0
`define VPBWD_BIT_PARITY_RESP 0
`define VPBWD_BIT_ISA_RANGE 2
`define VPBWD_BIT_VGA_ROUTE 3
`define VPBWD_FIELD_HI 15
`define VPBWD_FIELD_LO 4
`define VPBWD_IRQ_PARITY 0
`define VPBWD_IRQ_ABORT 1
`define VPBWD_IRQ_ILLEGAL 2
`define VPBWD_IRQ_SERR 3
`endif

// ---- verilog/vpbwd_pkg.sv ----
package vpbwd_pkg;
    typedef enum logic [1:0]
    {
        VPBWD_TGT_NONE = 2'h0,
        VPBWD_TGT_SEC = 2'h1,
        VPBWD_TGT_HUB = 2'h3
    } vpbwd_target_t;
    typedef enum logic [1:0]
    {
        VPBWD_CYC_MEM = 2'h0,
        VPBWD_CYC_IO = 2'h1,
        VPBWD_CYC_VGA = 2'h3,
        VPBWD_CYC_MDA = 2'h2
    } vpbwd_cycle_t;
endpackage

// ---- verilog/vpbwd_window_decode.sv ----
`timescale 1ns/1ps
`include "vpbwd_map.svh"

module vpbwd_window_decode
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    // processor cycle to route
    input wire logic cycValid,
    input wire vpbwd_pkg::vpbwd_cycle_t cycKind,
    input wire logic cycWrite,
    input wire logic [31:0] cycAddr,
    output vpbwd_pkg::vpbwd_target_t cycTarget,
    output logic cycIllegal,
    // settings held elsewhere
    input wire logic monoAdapterPresent,
    input wire logic [15:0] ioWindowBase,
    input wire logic [15:0] ioWindowLimit,
    input wire logic bridgeSysErrorEnable,
    // secondary bus mastering
    input wire logic secMasterAbort,
    input wire logic secMasterRead,
    input wire logic [31:0] secReadData,
    output logic [31:0] masterRdData,
    output logic masterWriteDrop,
    output logic secResetOut,
    output logic fastBackToBack,
    // error reporting
    input wire logic secParityError,
    output logic hubSerrMsg,
    output logic irq
);

    logic [11:0] pfBase_ff;
    logic [11:0] pfLimit_ff;
    logic vgaRoute_ff;
    logic isaRange_ff;
    logic parityResp_ff;
    logic [3:0] irqStatus_ff;
    logic [3:0] irqMask_ff;
    logic [3:0] nxt_irqStatus;
    logic [3:0] irqEvent;
    logic [15:0] nxt_rdData;
    logic [31:0] masterRdData_ff;
    logic masterWriteDrop_ff;
    logic hubSerrMsg_ff;
    logic inPfWindow;
    logic inIoWindow;
    logic isaAlias;
    logic serrReq;

    function automatic logic wrHit(input logic [7:0] addr, input logic [7:0] off, input logic stb);
        wrHit = stb && (addr == off);
    endfunction

    // window registers; low nibble is not stored
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pfBase_ff <= 12'(`VPBWD_RST_PF_BASE >> `VPBWD_FIELD_LO);
            pfLimit_ff <= 12'(`VPBWD_RST_PF_LIMIT >> `VPBWD_FIELD_LO);
        end
        else
        begin
            if (wrHit(regAddr, `VPBWD_OFF_PF_BASE, regWrStb))
                pfBase_ff <= regWrData[`VPBWD_FIELD_HI:`VPBWD_FIELD_LO];
            if (wrHit(regAddr, `VPBWD_OFF_PF_LIMIT, regWrStb))
                pfLimit_ff <= regWrData[`VPBWD_FIELD_HI:`VPBWD_FIELD_LO];
        end
    end

    // bridge control: only bits 3, 2 and 0 are stored
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            vgaRoute_ff <= 1'(`VPBWD_RST_BRIDGE_CTRL >> `VPBWD_BIT_VGA_ROUTE);
            isaRange_ff <= 1'b0;
            parityResp_ff <= 1'b0;
        end
        else if (wrHit(regAddr, `VPBWD_OFF_BRIDGE_CTRL, regWrStb))
        begin
            vgaRoute_ff <= regWrData[`VPBWD_BIT_VGA_ROUTE];
            isaRange_ff <= regWrData[`VPBWD_BIT_ISA_RANGE];
            parityResp_ff <= regWrData[`VPBWD_BIT_PARITY_RESP];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            irqMask_ff <= `VPBWD_RST_IRQ_MASK;
        else if (wrHit(regAddr, `VPBWD_OFF_IRQ_MASK, regWrStb))
            irqMask_ff <= regWrData[3:0];
    end

    // read mux; hardwired bits 7,6,5,4,1 read zero
    always_comb
    begin
        nxt_rdData = 16'h0000;
        unique case (regAddr)
            `VPBWD_OFF_PF_BASE: nxt_rdData = {pfBase_ff, 4'h0};
            `VPBWD_OFF_PF_LIMIT: nxt_rdData = {pfLimit_ff, 4'h0};
            `VPBWD_OFF_BRIDGE_CTRL:
                nxt_rdData = {8'h00, 4'h0, vgaRoute_ff, isaRange_ff, 1'b0, parityResp_ff};
            `VPBWD_OFF_IRQ_STATUS: nxt_rdData = {12'h000, irqStatus_ff};
            `VPBWD_OFF_IRQ_MASK: nxt_rdData = {12'h000, irqMask_ff};
            default: nxt_rdData = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            regRdData <= 16'h0000;
        else if (regRdStb)
            regRdData <= nxt_rdData;
        else
            regRdData <= 16'h0000;
    end

    // address decode
    assign inPfWindow = (cycAddr >= {pfBase_ff, 20'h00000})
        && (cycAddr <= {pfLimit_ff, 20'hFFFFF});
    assign inIoWindow = (cycAddr[15:0] >= ioWindowBase) && (cycAddr[15:0] <= ioWindowLimit);
    // offsets 100h-3FFh within each 1-KB block
    assign isaAlias = (cycAddr[9:8] != 2'h0);

    always_comb
    begin
        cycTarget = vpbwd_pkg::VPBWD_TGT_NONE;
        cycIllegal = 1'b0;
        if (cycValid)
        begin
            unique case (cycKind)
                vpbwd_pkg::VPBWD_CYC_MEM:
                    cycTarget = inPfWindow ? vpbwd_pkg::VPBWD_TGT_SEC : vpbwd_pkg::VPBWD_TGT_NONE;
                vpbwd_pkg::VPBWD_CYC_IO:
                    if (inIoWindow)
                        cycTarget = (isaRange_ff && isaAlias) ? vpbwd_pkg::VPBWD_TGT_HUB
                            : vpbwd_pkg::VPBWD_TGT_SEC;
                vpbwd_pkg::VPBWD_CYC_VGA:
                begin
                    cycTarget = vgaRoute_ff ? vpbwd_pkg::VPBWD_TGT_SEC : vpbwd_pkg::VPBWD_TGT_HUB;
                    cycIllegal = !vgaRoute_ff && monoAdapterPresent;
                end
                vpbwd_pkg::VPBWD_CYC_MDA:
                begin
                    cycTarget = vpbwd_pkg::VPBWD_TGT_HUB;
                    cycIllegal = !vgaRoute_ff && monoAdapterPresent;
                end
            endcase
        end
    end

    // master abort: reads return ones, writes are discarded
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            masterRdData_ff <= 32'h00000000;
            masterWriteDrop_ff <= 1'b0;
        end
        else
        begin
            masterRdData_ff <= secMasterAbort ? 32'hFFFFFFFF : secReadData;
            masterWriteDrop_ff <= secMasterAbort && !secMasterRead;
        end
    end
    assign masterRdData = masterRdData_ff;
    assign masterWriteDrop = masterWriteDrop_ff;
    assign secResetOut = 1'b0;
    assign fastBackToBack = 1'b0;

    // system error message on parity error
    assign serrReq = secParityError && parityResp_ff && bridgeSysErrorEnable;
    always_ff @(posedge core_clk)
    begin
        if (srst)
            hubSerrMsg_ff <= 1'b0;
        else
            hubSerrMsg_ff <= serrReq;
    end
    assign hubSerrMsg = hubSerrMsg_ff;

    // interrupt status: read clears, new event wins
    assign irqEvent = {serrReq, cycIllegal, secMasterAbort, secParityError};
    always_comb
    begin
        nxt_irqStatus = irqStatus_ff;
        if (regRdStb && regAddr == `VPBWD_OFF_IRQ_STATUS)
            nxt_irqStatus = 4'h0;
        nxt_irqStatus = nxt_irqStatus | irqEvent;
    end
    always_ff @(posedge core_clk)
    begin
        if (srst)
            irqStatus_ff <= 4'h0;
        else
            irqStatus_ff <= nxt_irqStatus;
    end
    assign irq = |(irqStatus_ff & irqMask_ff);

    AST_PF_WINDOW: assert property (@(posedge core_clk) disable iff (srst)
        cycValid && cycKind == vpbwd_pkg::VPBWD_CYC_MEM && cycAddr[31:20] >= pfBase_ff
        && cycAddr[31:20] <= pfLimit_ff |-> cycTarget == vpbwd_pkg::VPBWD_TGT_SEC)
        else $error("prefetch window hit not routed to secondary");
    AST_PF_RESET_EMPTY: assert property (@(posedge core_clk)
        $past(srst) && !srst |-> pfBase_ff > pfLimit_ff)
        else $error("window not empty after reset");
    AST_BASE_LOW_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        regRdStb && regAddr == `VPBWD_OFF_PF_BASE |=> regRdData[3:0] == 4'h0)
        else $error("base low bits not zero");
    AST_LIMIT_READBACK: assert property (@(posedge core_clk) disable iff (srst)
        regWrStb && regAddr == `VPBWD_OFF_PF_LIMIT ##1 regRdStb && regAddr == `VPBWD_OFF_PF_LIMIT
        |=> regRdData == {$past(regWrData, 2) & 16'hFFF0})
        else $error("limit readback wrong");
    AST_CTRL_HARDWIRED: assert property (@(posedge core_clk) disable iff (srst)
        regRdStb && regAddr == `VPBWD_OFF_BRIDGE_CTRL |=> (regRdData & 16'hFFF2) == 16'h0000)
        else $error("hardwired control bits not zero");
    AST_NO_SEC_RESET: assert property (@(posedge core_clk) disable iff (srst)
        !secResetOut && !fastBackToBack)
        else $error("secondary reset or fast back-to-back driven");
    AST_ABORT_ONES: assert property (@(posedge core_clk) disable iff (srst)
        secMasterAbort && secMasterRead |=> masterRdData == 32'hFFFFFFFF && !masterWriteDrop)
        else $error("master abort read not all ones");
    AST_ISA_HUB: assert property (@(posedge core_clk) disable iff (srst)
        cycValid && cycKind == vpbwd_pkg::VPBWD_CYC_IO && inIoWindow && isaRange_ff
        && cycAddr[9:8] != 2'h0 |-> cycTarget == vpbwd_pkg::VPBWD_TGT_HUB)
        else $error("ISA alias not sent to hub");
    AST_IO_OUTSIDE: assert property (@(posedge core_clk) disable iff (srst)
        cycValid && cycKind == vpbwd_pkg::VPBWD_CYC_IO && !inIoWindow |-> cycTarget == vpbwd_pkg::VPBWD_TGT_NONE)
        else $error("out-of-window I/O claimed");
    AST_MDA_HUB: assert property (@(posedge core_clk) disable iff (srst)
        cycValid && cycKind == vpbwd_pkg::VPBWD_CYC_MDA |-> cycTarget == vpbwd_pkg::VPBWD_TGT_HUB)
        else $error("MDA not routed to hub");
    AST_SERR_GATE: assert property (@(posedge core_clk) disable iff (srst)
        hubSerrMsg |-> $past(parityResp_ff) && $past(bridgeSysErrorEnable) && $past(secParityError))
        else $error("system error message without enables");
    AST_STATUS_SET_WINS: assert property (@(posedge core_clk) disable iff (srst)
        regRdStb && regAddr == `VPBWD_OFF_IRQ_STATUS && secParityError |=> irqStatus_ff[`VPBWD_IRQ_PARITY])
        else $error("status event lost under read clear");
    AST_RD_IDLE_ZERO: assert property (@(posedge core_clk) disable iff (srst)
        !regRdStb |=> regRdData == 16'h0000)
        else $error("read data not zero outside read answer");

    COV_PF_HIT: cover property (@(posedge core_clk) disable iff (srst)
        cycValid && cycTarget == vpbwd_pkg::VPBWD_TGT_SEC && cycKind == vpbwd_pkg::VPBWD_CYC_MEM);
    COV_ISA_HUB: cover property (@(posedge core_clk) disable iff (srst)
        cycValid && cycKind == vpbwd_pkg::VPBWD_CYC_IO && cycTarget == vpbwd_pkg::VPBWD_TGT_HUB);
    COV_SERR: cover property (@(posedge core_clk) disable iff (srst) hubSerrMsg);
    COV_IRQ: cover property (@(posedge core_clk) disable iff (srst) irq);

endmodule

// ---- verif/vpbwd_sec_agent.sv ----
`timescale 1ns/1ps

module vpbwd_sec_agent
(
    // clock
    input wire logic core_clk,
    // orders from the bench
    input wire logic go,
    input wire logic wantAbort,
    input wire logic wantRead,
    input wire logic wantParity,
    input wire logic [31:0] wantData,
    // secondary bus answers
    output logic secMasterAbort,
    output logic secMasterRead,
    output logic [31:0] secReadData,
    output logic secParityError
);
    initial
    begin
        secMasterAbort = 1'b0;
        secMasterRead = 1'b0;
        secParityError = 1'b0;
        secReadData = 32'h0;
    end

    // one-cycle answer; idle data keeps toggling so a stale word never looks valid
    always @(posedge core_clk)
    begin
        secMasterAbort <= go & wantAbort;
        secMasterRead <= go & wantRead;
        secParityError <= go & wantParity;
        secReadData <= go ? wantData : ~secReadData;
    end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`include "vpbwd_map.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end

module tb_top;
    typedef struct {vpbwd_pkg::vpbwd_cycle_t k; logic [31:0] a; vpbwd_pkg::vpbwd_target_t t;} vpbwd_row_t;
    logic core_clk = 1'b0, srst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, cycValid = 1'b0, cycWrite = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [15:0] regWrData = 16'h0, regRdData, rdVal, ioWindowBase = 16'h1000, ioWindowLimit = 16'h1FFF;
    logic [31:0] cycAddr = 32'h0, secReadData, masterRdData, wantData = 32'h0;
    logic monoAdapterPresent = 1'b0, bridgeSysErrorEnable = 1'b0, go = 1'b0, wantAbort = 1'b0;
    logic wantRead = 1'b0, wantParity = 1'b0, secMasterAbort, secMasterRead, secParityError;
    logic cycIllegal, masterWriteDrop, secResetOut, fastBackToBack, hubSerrMsg, irq;
    vpbwd_pkg::vpbwd_cycle_t cycKind = vpbwd_pkg::VPBWD_CYC_MEM;
    vpbwd_pkg::vpbwd_target_t cycTarget;
    int err_total = 0;
    int cmp_count = 0;
    vpbwd_row_t rows [10] = '{
        '{vpbwd_pkg::VPBWD_CYC_MEM, 32'h0100_0000, vpbwd_pkg::VPBWD_TGT_SEC},
        '{vpbwd_pkg::VPBWD_CYC_MEM, 32'h00FF_FFFF, vpbwd_pkg::VPBWD_TGT_NONE},
        '{vpbwd_pkg::VPBWD_CYC_MEM, 32'h020F_FFFF, vpbwd_pkg::VPBWD_TGT_SEC},
        '{vpbwd_pkg::VPBWD_CYC_MEM, 32'h0210_0000, vpbwd_pkg::VPBWD_TGT_NONE},
        '{vpbwd_pkg::VPBWD_CYC_IO, 32'h0000_1000, vpbwd_pkg::VPBWD_TGT_SEC},
        '{vpbwd_pkg::VPBWD_CYC_IO, 32'h0000_10FF, vpbwd_pkg::VPBWD_TGT_SEC},
        '{vpbwd_pkg::VPBWD_CYC_IO, 32'h0000_1100, vpbwd_pkg::VPBWD_TGT_HUB},
        '{vpbwd_pkg::VPBWD_CYC_IO, 32'h0000_13FF, vpbwd_pkg::VPBWD_TGT_HUB},
        '{vpbwd_pkg::VPBWD_CYC_VGA, 32'h000A_0000, vpbwd_pkg::VPBWD_TGT_SEC},
        '{vpbwd_pkg::VPBWD_CYC_MDA, 32'h000B_0000, vpbwd_pkg::VPBWD_TGT_HUB}};

    always #20 core_clk = ~core_clk;

    vpbwd_window_decode vpbwd_window_decode_i (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .cycValid(cycValid), .cycKind(cycKind), .cycWrite(cycWrite), .cycAddr(cycAddr), .cycTarget(cycTarget),
        .cycIllegal(cycIllegal), .monoAdapterPresent(monoAdapterPresent), .ioWindowBase(ioWindowBase),
        .ioWindowLimit(ioWindowLimit), .bridgeSysErrorEnable(bridgeSysErrorEnable),
        .secMasterAbort(secMasterAbort), .secMasterRead(secMasterRead), .secReadData(secReadData),
        .masterRdData(masterRdData), .masterWriteDrop(masterWriteDrop), .secResetOut(secResetOut),
        .fastBackToBack(fastBackToBack), .secParityError(secParityError), .hubSerrMsg(hubSerrMsg), .irq(irq));

    vpbwd_sec_agent vpbwd_sec_agent_i (.core_clk(core_clk), .go(go), .wantAbort(wantAbort), .wantRead(wantRead),
        .wantParity(wantParity), .wantData(wantData), .secMasterAbort(secMasterAbort),
        .secMasterRead(secMasterRead), .secReadData(secReadData), .secParityError(secParityError));

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        `CHK("regRdData", e, rdVal)
    endtask

    task automatic dec(input vpbwd_pkg::vpbwd_cycle_t k, input logic [31:0] a, input vpbwd_pkg::vpbwd_target_t t);
        @(posedge core_clk);
        cycValid <= 1'b1;
        cycKind <= k;
        cycAddr <= a;
        #1;
        `CHK("cycTarget", t, cycTarget)
    endtask

    // one agent answer, then wait until the bridge has registered its reaction
    task automatic sec(input logic ab, input logic rq, input logic par, input logic [31:0] d);
        @(posedge core_clk);
        go <= 1'b1;
        wantAbort <= ab;
        wantRead <= rq;
        wantParity <= par;
        wantData <= d;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        rdchk(`VPBWD_OFF_PF_BASE, `VPBWD_RST_PF_BASE);
        rdchk(`VPBWD_OFF_PF_LIMIT, `VPBWD_RST_PF_LIMIT);
        rdchk(`VPBWD_OFF_BRIDGE_CTRL, 16'h0000);
        dec(vpbwd_pkg::VPBWD_CYC_MEM, 32'hFFF0_0000, vpbwd_pkg::VPBWD_TGT_NONE);
        wr(`VPBWD_OFF_PF_BASE, 16'hFFFF);
        rdchk(`VPBWD_OFF_PF_BASE, 16'hFFF0);
        wr(`VPBWD_OFF_BRIDGE_CTRL, 16'h00FF);
        rdchk(`VPBWD_OFF_BRIDGE_CTRL, 16'h000D);
        `CHK("secResetOut", 1'b0, secResetOut)
        `CHK("fastBackToBack", 1'b0, fastBackToBack)
        rdchk(8'h40, 16'h0000);
        wr(`VPBWD_OFF_PF_BASE, 16'h0100);
        wr(`VPBWD_OFF_PF_LIMIT, 16'h0200);
        rdchk(`VPBWD_OFF_PF_LIMIT, 16'h0200);
        foreach (rows[i])
            dec(rows[i].k, rows[i].a, rows[i].t);
        wr(`VPBWD_OFF_BRIDGE_CTRL, 16'h0009);
        dec(vpbwd_pkg::VPBWD_CYC_IO, 32'h0000_1100, vpbwd_pkg::VPBWD_TGT_SEC);
        wr(`VPBWD_OFF_BRIDGE_CTRL, 16'h0001);
        dec(vpbwd_pkg::VPBWD_CYC_VGA, 32'h000A_0000, vpbwd_pkg::VPBWD_TGT_HUB);
        `CHK("cycIllegal", 1'b0, cycIllegal)
        @(posedge core_clk);
        monoAdapterPresent <= 1'b1;
        dec(vpbwd_pkg::VPBWD_CYC_MDA, 32'h000B_0000, vpbwd_pkg::VPBWD_TGT_HUB);
        `CHK("cycIllegal", 1'b1, cycIllegal)
        @(posedge core_clk);
        cycValid <= 1'b0;
        monoAdapterPresent <= 1'b0;
        #1;
        `CHK("cycTarget", vpbwd_pkg::VPBWD_TGT_NONE, cycTarget)
        sec(1'b1, 1'b1, 1'b0, 32'h1234_5678);
        `CHK("masterRdData", 32'hFFFF_FFFF, masterRdData)
        sec(1'b0, 1'b1, 1'b0, 32'h1234_5678);
        `CHK("masterRdData", 32'h1234_5678, masterRdData)
        sec(1'b1, 1'b0, 1'b0, 32'h0);
        `CHK("masterWriteDrop", 1'b1, masterWriteDrop)
        sec(1'b0, 1'b0, 1'b1, 32'h0);
        `CHK("hubSerrMsg", 1'b0, hubSerrMsg)
        @(posedge core_clk);
        bridgeSysErrorEnable <= 1'b1;
        wr(`VPBWD_OFF_BRIDGE_CTRL, 16'h0000);
        sec(1'b0, 1'b0, 1'b1, 32'h0);
        `CHK("hubSerrMsg", 1'b0, hubSerrMsg)
        wr(`VPBWD_OFF_BRIDGE_CTRL, 16'h0001);
        rd(`VPBWD_OFF_IRQ_STATUS);
        sec(1'b0, 1'b0, 1'b1, 32'h0);
        `CHK("hubSerrMsg", 1'b1, hubSerrMsg)
        @(posedge core_clk);
        #1;
        `CHK("irq", 1'b0, irq)
        wr(`VPBWD_OFF_IRQ_MASK, 16'h0001);
        @(posedge core_clk);
        #1;
        `CHK("irq", 1'b1, irq)
        rdchk(`VPBWD_OFF_IRQ_STATUS, 16'h0009);
        @(posedge core_clk);
        #1;
        `CHK("irq", 1'b0, irq)
        `CHK("regRdData", 16'h0000, regRdData)
        tally_and_finish();
    end

    initial
    begin
        repeat (2000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end
endmodule
